// ### verilog/serial_in_latched_sink_driver.sv
// shift register, output latches and sink gating of the 16-channel driver
`timescale 1ns/100ps
`include "sink_driver_defines.svh"
module serial_in_latched_sink_driver #(
  parameter int CHANNELS = `CHANNEL_COUNT,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic shiftClock,
  input wire logic serialDataIn,
  input wire logic latchStrobe,
  input wire logic outputEnableN,
  input wire logic shiftHold,
  output logic serialDataOut,
  output logic [CHANNELS-1:0] sinkChannelN,
  output logic shiftOverrun
);

  // shift one bit in at the low end; used by the logic and its checks
  function automatic logic [CHANNELS-1:0] shiftIn(input logic [CHANNELS-1:0] pattern,
                                                  input logic bitIn);
    shiftIn = {pattern[CHANNELS-2:0], bitIn};
  endfunction

  // drive level of the sink pins: low only for a set bit while enabled
  function automatic logic [CHANNELS-1:0] sinkDrive(input logic [CHANNELS-1:0] latched,
                                                    input logic enableN);
    sinkDrive = enableN ? {CHANNELS{1'b1}} : ~latched;
  endfunction

  // ---------------------------------------------------------------
  // pin synchroniser: three stages, a change counts once 2 and 3 agree
  // ---------------------------------------------------------------
  logic [`PIN_COUNT-1:0] pinRaw;                  // pins gathered in one vector
  logic [`PIN_COUNT-1:0] syncStage1_r, syncStage1_nxt; // metastability catcher
  logic [`PIN_COUNT-1:0] syncStage2_r, syncStage2_nxt; // second stage
  logic [`PIN_COUNT-1:0] syncStage3_r, syncStage3_nxt; // third stage
  logic [`PIN_COUNT-1:0] pinLevel_r, pinLevel_nxt;     // accepted pin levels

  assign pinRaw[`PIN_CLK] = shiftClock;
  assign pinRaw[`PIN_DATA] = serialDataIn;
  assign pinRaw[`PIN_STROBE] = latchStrobe;
  assign pinRaw[`PIN_ENABLE] = outputEnableN;

  // next values of the synchroniser chain and the accepted level;
  // stage 1 is read only by stage 2
  always_comb begin
    syncStage1_nxt = pinRaw;
    syncStage2_nxt = syncStage1_r;
    syncStage3_nxt = syncStage2_r;
    pinLevel_nxt = pinLevel_r;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      // a one-sample glitch never reaches the accepted level
      if (syncStage2_r[i] == syncStage3_r[i]) begin
        pinLevel_nxt[i] = syncStage3_r[i];
      end
    end
  end

  // register the synchroniser; enable resets inactive so sinks start off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      syncStage1_r <= `PIN_RESET;
      syncStage2_r <= `PIN_RESET;
      syncStage3_r <= `PIN_RESET;
      pinLevel_r <= `PIN_RESET;
    end else begin
      syncStage1_r <= syncStage1_nxt;
      syncStage2_r <= syncStage2_nxt;
      syncStage3_r <= syncStage3_nxt;
      pinLevel_r <= pinLevel_nxt;
    end
  end

  // ---------------------------------------------------------------
  // edge finding on the accepted levels
  // ---------------------------------------------------------------
  logic clockRise;   // accepted shift clock goes low to high
  logic strobeRise;  // accepted strobe goes low to high

  // only rising edges act; a falling shift clock changes nothing
  assign clockRise = pinLevel_nxt[`PIN_CLK] && !pinLevel_r[`PIN_CLK];
  assign strobeRise = pinLevel_nxt[`PIN_STROBE] && !pinLevel_r[`PIN_STROBE];

  // ---------------------------------------------------------------
  // event words into the fifo
  // ---------------------------------------------------------------
  logic fillValid;                       // an event wants into the fifo
  logic fillReady;                       // fifo can take it
  logic [`WORD_WIDTH-1:0] fillWord;      // event word being offered
  logic drainValid;                      // fifo holds an event
  logic drainReady;                      // shift logic can take it
  logic [`WORD_WIDTH-1:0] drainWord;     // oldest event word
  logic drainFire;                       // event applied this cycle
  logic headData;                        // data bit of the oldest event
  logic headStrobe;                      // strobe level of the oldest event
  sink_driver_pkg::word_kind_type headKind; // shift or latch only

  // data and strobe are taken from the levels before the edge, which
  // honours the host's setup time across the synchroniser
  always_comb begin
    fillWord = '0;
    fillValid = 1'b0;
    if (clockRise) begin
      fillValid = 1'b1;
      fillWord[`WORD_DATA_BIT] = pinLevel_r[`PIN_DATA];
      fillWord[`WORD_STROBE_BIT] = pinLevel_r[`PIN_STROBE];
      fillWord[`WORD_KIND_BIT] = sink_driver_pkg::WORD_SHIFT;
    end else if (strobeRise) begin
      // a strobe pulse with no clock edge still copies the pattern into the latches
      fillValid = 1'b1;
      fillWord[`WORD_STROBE_BIT] = 1'b1;
      fillWord[`WORD_KIND_BIT] = sink_driver_pkg::WORD_LATCH;
    end
  end

  // the draining side stalls while held, so a long hold fills the fifo
  assign drainReady = !shiftHold;
  assign drainFire = drainValid && drainReady;
  assign headData = drainWord[`WORD_DATA_BIT];
  assign headStrobe = drainWord[`WORD_STROBE_BIT];
  assign headKind = sink_driver_pkg::word_kind_type'(drainWord[`WORD_KIND_BIT]);

  event_fifo #(
    .WIDTH(`WORD_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) eventBuffer (
    .sys_clk(sys_clk),
    .reset(reset),
    .inValid(fillValid),
    .inReady(fillReady),
    .inData(fillWord),
    .outValid(drainValid),
    .outReady(drainReady),
    .outData(drainWord)
  );

  // ---------------------------------------------------------------
  // shift register, latches and serial tail
  // ---------------------------------------------------------------
  logic [CHANNELS-1:0] shift_r, shift_nxt;   // stage 0 holds the newest bit
  logic [CHANNELS-1:0] latch_r, latch_nxt;   // output latches
  logic serialOut_r, serialOut_nxt;          // registered tail stage
  logic overrun_r, overrun_nxt;              // sticky lost-event flag

  // apply the oldest buffered event
  always_comb begin
    shift_nxt = shift_r;
    latch_nxt = latch_r;
    overrun_nxt = overrun_r;
    if (drainFire) begin
      unique case (headKind)
        sink_driver_pkg::WORD_SHIFT: begin
          shift_nxt = shiftIn(shift_r, headData);
          // strobe high: latches take the pattern including the new bit
          if (headStrobe) begin
            latch_nxt = shift_nxt;
          end
        end
        sink_driver_pkg::WORD_LATCH: begin
          latch_nxt = shift_r;
        end
      endcase
    end
    // an event that finds the fifo full is lost; the host ran too fast
    if (fillValid && !fillReady) begin
      overrun_nxt = 1'b1;
    end
    serialOut_nxt = shift_nxt[CHANNELS-1];
  end

  // register the shift state; no reset exists on the pins, so the
  // pattern starts cleared and the channels start off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shift_r <= `PATTERN_RESET;
      latch_r <= `PATTERN_RESET;
      serialOut_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      latch_r <= latch_nxt;
      serialOut_r <= serialOut_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  // ---------------------------------------------------------------
  // sink outputs
  // ---------------------------------------------------------------
  logic [CHANNELS-1:0] sink_r, sink_nxt; // per-channel pin levels

  // each channel is its own latch bit gated by the enable level;
  // registering costs a cycle but keeps glitches off the pins
  always_comb begin
    sink_nxt = sinkDrive(latch_r, pinLevel_r[`PIN_ENABLE]);
  end

  // register the sink pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sink_r <= `SINK_ALL_OFF;
    end else begin
      sink_r <= sink_nxt;
    end
  end

  assign sinkChannelN = sink_r;
  assign serialDataOut = serialOut_r;
  assign shiftOverrun = overrun_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // a shift word moves the pattern by one and enters the bit at stage 0
  shift_step_a: assert property (@(posedge sys_clk) disable iff (reset)
    drainFire && headKind == sink_driver_pkg::WORD_SHIFT
      |=> shift_r == shiftIn($past(shift_r), $past(headData)))
    else $error("shift register did not advance by one");

  // strobe high on a shift edge: latches equal the shifted pattern
  latch_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
    drainFire && headKind == sink_driver_pkg::WORD_SHIFT && headStrobe
      |=> latch_r == shift_r)
    else $error("latches did not follow with strobe high");

  // with strobe low or no event the latches hold
  latch_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !drainFire || (headKind == sink_driver_pkg::WORD_SHIFT && !headStrobe)
      |=> $stable(latch_r))
    else $error("latches changed with strobe low");

  // a strobe pulse alone copies the shift register without shifting
  strobe_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
    drainFire && headKind == sink_driver_pkg::WORD_LATCH
      |=> latch_r == $past(shift_r) && $stable(shift_r))
    else $error("strobe pulse did not transfer the pattern");

  // after a shift the tail holds what stage 14 held, the bit from fifteen shifts back
  serial_tail_a: assert property (@(posedge sys_clk) disable iff (reset)
    drainFire && headKind == sink_driver_pkg::WORD_SHIFT
      |=> serialDataOut == $past(shift_r[CHANNELS-2]))
    else $error("serial output is not the last stage");

  // newest bit reaches channel 0 when latched in the same event
  newest_bit_a: assert property (@(posedge sys_clk) disable iff (reset)
    drainFire && headKind == sink_driver_pkg::WORD_SHIFT && headStrobe
      |=> latch_r[0] == $past(headData))
    else $error("newest bit did not land on channel 0");

  // enabled: each set latch bit pulls its channel low a cycle later
  sink_enabled_a: assert property (@(posedge sys_clk) disable iff (reset)
    !pinLevel_r[`PIN_ENABLE] |=> sinkChannelN == ~$past(latch_r))
    else $error("enabled channels do not match the latches");

  // disabled: every channel off regardless of the latches
  sink_disabled_a: assert property (@(posedge sys_clk) disable iff (reset)
    pinLevel_r[`PIN_ENABLE] |=> sinkChannelN == `SINK_ALL_OFF)
    else $error("channel sinking while disabled");

  // an accepted rising clock edge reaches the fifo unless it is full
  clock_capture_a: assert property (@(posedge sys_clk) disable iff (reset)
    clockRise && fillReady |=> drainValid)
    else $error("rising shift clock was not captured");

  // a falling shift clock on its own queues nothing
  fall_ignored_a: assert property (@(posedge sys_clk) disable iff (reset)
    pinLevel_r[`PIN_CLK] && !pinLevel_nxt[`PIN_CLK] && !strobeRise
      |-> !fillValid)
    else $error("falling shift clock queued an event");

  // a stalled drain freezes the pattern and the latches
  hold_stall_a: assert property (@(posedge sys_clk) disable iff (reset)
    shiftHold
      |=> $stable(shift_r) && $stable(latch_r))
    else $error("pattern moved while the drain was stalled");

  // an event refused by a full buffer raises the overrun flag
  overrun_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    fillValid && !fillReady
      |=> shiftOverrun)
    else $error("dropped event did not raise overrun");

  // only reset clears the overrun flag; software has no clear path
  overrun_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    shiftOverrun
      |=> shiftOverrun)
    else $error("overrun flag cleared without reset");

endmodule

// ### verilog/sink_driver_defines.svh
// named constants for the serial-in latched sink driver
`ifndef SINK_DRIVER_DEFINES_SVH
`define SINK_DRIVER_DEFINES_SVH

// channel count and pattern reset values
`define CHANNEL_COUNT 16
`define PATTERN_RESET 16'h0000
`define SINK_ALL_OFF 16'hffff

// pin synchroniser: depth and bit positions of the four sampled pins
`define SYNC_STAGES 3
`define PIN_COUNT 4
`define PIN_CLK 0
`define PIN_DATA 1
`define PIN_STROBE 2
`define PIN_ENABLE 3
// enable pin resets high so the channels start off
`define PIN_RESET 4'h8

// buffered event word: one bit each for data, strobe level and kind
`define WORD_WIDTH 3
`define WORD_DATA_BIT 0
`define WORD_STROBE_BIT 1
`define WORD_KIND_BIT 2
`define FIFO_DEPTH 32

`endif

// ### verilog/sink_driver_pkg.sv
// types shared by the sink driver files
package sink_driver_pkg;
  // one parallel output pattern
  typedef logic [15:0] pattern_type;
  // what a buffered event word asks the shift logic to do
  typedef enum logic {
    WORD_SHIFT,
    WORD_LATCH
  } word_kind_type;
endpackage

// ### verilog/event_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module event_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];      // storage words
  logic [PW:0] wrPtr_r, wrPtr_nxt;     // write pointer with wrap bit
  logic [PW:0] rdPtr_r, rdPtr_nxt;     // read pointer with wrap bit
  logic [PW:0] count;                  // words held
  logic fillFire;                      // word taken on filling side
  logic drainFire;                     // word handed on draining side

  // honest full and empty from the pointer distance
  assign count = wrPtr_r - rdPtr_r;
  assign inReady = (count != DEPTH[PW:0]);
  assign outValid = (count != '0);
  assign outData = mem[rdPtr_r[PW-1:0]];
  assign fillFire = inValid && inReady;
  assign drainFire = outValid && outReady;

  // next pointer values
  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    if (fillFire) begin
      wrPtr_nxt = wrPtr_r + 1'b1;
    end
    if (drainFire) begin
      rdPtr_nxt = rdPtr_r + 1'b1;
    end
  end

  // register pointers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  // storage needs no reset; nothing reads a slot before it is written
  always_ff @(posedge sys_clk) begin
    if (fillFire) begin
      mem[wrPtr_r[PW-1:0]] <= inData;
    end
  end

  // a full fifo must refuse the next word, so the distance never passes the depth
  fifo_full_a: assert property (@(posedge sys_clk) disable iff (reset)
    count <= DEPTH[PW:0])
    else $error("fifo held more words than its depth");
endmodule

// ### verification/host_model.sv
// host-side model that drives the sink driver's serial pins
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  output logic shiftClock,
  output logic serialDataIn,
  output logic latchStrobe,
  output logic outputEnableN
);
  // four system clocks of setup, four high and one after the fall give a shift period of at least 225 ns, well under the limit
  localparam int HALF = 4;

  // pins idle: clock and strobe low, outputs disabled
  initial begin
    shiftClock = 1'b0;
    serialDataIn = 1'b0;
    latchStrobe = 1'b0;
    outputEnableN = 1'b1;
  end

  // one bit per rising clock; clock stands still between calls
  task automatic shift_bit(input logic b);
    serialDataIn = b;
    repeat (HALF) @(negedge sys_clk);
    shiftClock = 1'b1;
    repeat (HALF) @(negedge sys_clk);
    shiftClock = 1'b0;
    @(negedge sys_clk);
    // hold time is over, so the line no longer shows the bit
    serialDataIn = ~b;
  endtask

  // low-high-low strobe after the shifting is done
  task automatic pulse_strobe();
    latchStrobe = 1'b1;
    repeat (HALF) @(negedge sys_clk);
    latchStrobe = 1'b0;
  endtask

  // strobe held as a level, for the transparent case
  task automatic set_strobe(input logic v);
    latchStrobe = v;
  endtask

  // active-low output enable
  task automatic set_enable(input logic v);
    outputEnableN = v;
  endtask
endmodule

// ### verification/serial_in_latched_sink_driver_tb.sv
// self-checking bench for the serial-in latched sink driver
`timescale 1ns/100ps
module serial_in_latched_sink_driver_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic shiftHold = 1'b0; // stalls the event drain
  logic shiftClock;
  logic serialDataIn;
  logic latchStrobe;
  logic outputEnableN;
  logic serialDataOut;
  logic shiftOverrun;
  logic [15:0] sinkChannelN;
  int errCount = 0;
  int nChecks = 0;
  int shiftM = 0; // model shift register, bit 0 newest
  int latchM = 0; // model output latches
  logic enM = 1'b1; // model enable level, active low
  logic [31:0] lfsrState = 32'ha557;
  logic pend[$]; // bits parked while the drain is stalled

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  serial_in_latched_sink_driver u_serial_in_latched_sink_driver (
    .sys_clk(sys_clk),
    .reset(reset),
    .shiftClock(shiftClock),
    .serialDataIn(serialDataIn),
    .latchStrobe(latchStrobe),
    .outputEnableN(outputEnableN),
    .shiftHold(shiftHold),
    .serialDataOut(serialDataOut),
    .sinkChannelN(sinkChannelN),
    .shiftOverrun(shiftOverrun)
  );

  host_model u_host_model (
    .sys_clk(sys_clk),
    .shiftClock(shiftClock),
    .serialDataIn(serialDataIn),
    .latchStrobe(latchStrobe),
    .outputEnableN(outputEnableN)
  );

  // pseudo-random source for data patterns
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // single comparison point; four-state compare so unknowns fail
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  // channels and serial tail against the model
  task automatic compare_all();
    logic [15:0] expCh;
    expCh = enM ? 16'hffff : ~latchM[15:0];
    check(sinkChannelN, expCh);
    check({15'h0000, serialDataOut}, {15'h0000, shiftM[15]});
  endtask

  // wait past the falling clock too, so a fall that moved anything shows up
  task automatic send_bit(input logic b);
    u_host_model.shift_bit(b);
    shiftM = {shiftM[14:0], b};
    if (latchStrobe) begin
      latchM = shiftM;
    end
    repeat (5) @(negedge sys_clk);
    compare_all();
  endtask

  // strobe pulse copies the shift pattern into the latches
  task automatic strobe();
    u_host_model.pulse_strobe();
    latchM = shiftM;
    repeat (2) @(negedge sys_clk);
    compare_all();
  endtask

  // enable change reaches the pins in about five system clocks
  task automatic enable(input logic v);
    u_host_model.set_enable(v);
    enM = v;
    repeat (6) @(negedge sys_clk);
    compare_all();
  endtask

  // synchronous reset for six cycles; the model returns to empty patterns
  task automatic do_reset();
    reset = 1'b1;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    shiftM = 0;
    latchM = 0;
    repeat (5) @(negedge sys_clk);
  endtask

  // verdict and end of run
  task automatic close_out();
    if (errCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    do_reset();
    compare_all();
    check({15'h0000, shiftOverrun}, 16'h0000);
    enable(1'b0);
    // random words, msb first, latched by a pulse; outputs held off for one word
    for (int w = 0; w < 4; w++) begin
      lfsrState = lfsr_next(lfsrState);
      for (int i = 15; i >= 0; i--) send_bit(lfsrState[i]);
      strobe();
      if (w == 2) begin
        enable(1'b1);
      end
    end
    enable(1'b0);
    // strobe held high: latches follow every shift
    u_host_model.set_strobe(1'b1);
    latchM = shiftM;
    repeat (6) @(negedge sys_clk);
    compare_all();
    for (int i = 0; i < 3; i++) send_bit(i[0]);
    u_host_model.set_strobe(1'b0);
    repeat (6) @(negedge sys_clk);
    // fill the event buffer with the drain stalled until it refuses
    shiftHold = 1'b1;
    for (int i = 0; i < 33; i++) begin
      lfsrState = lfsr_next(lfsrState);
      u_host_model.shift_bit(lfsrState[0]);
      if (i < 32) begin
        pend.push_back(lfsrState[0]);
      end
      repeat (2) @(negedge sys_clk);
      compare_all();
      check({15'h0000, shiftOverrun}, (i < 32) ? 16'h0000 : 16'h0001);
    end
    // drain to empty: the 32 kept bits land, the dropped one does not
    shiftHold = 1'b0;
    repeat (40) @(negedge sys_clk);
    while (pend.size() > 0) begin
      shiftM = {shiftM[14:0], pend.pop_front()};
    end
    compare_all();
    strobe();
    check({15'h0000, shiftOverrun}, 16'h0001);
    // mid-run reset clears the sticky flag and the patterns
    enable(1'b1);
    do_reset();
    check({15'h0000, shiftOverrun}, 16'h0000);
    compare_all();
    close_out();
  end

  // watchdog: the sequence needs about 1430 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    close_out();
  end
endmodule
